// ===== core/rmc_defines.vh
// register offsets, field positions and reset values of the redriver control registers
`ifndef RMC_DEFINES_VH
`define RMC_DEFINES_VH
// register offsets
`define RMC_ADDR_PWR 8'h09
`define RMC_ADDR_HPD 8'h0A
`define RMC_ADDR_CLK 8'h0B
`define RMC_PTR_RST 8'h00
// power_and_detect_control fields
`define RMC_DET_EN_BIT 4
`define RMC_PD_BIT 3
`define RMC_HP_SLEEP_DIS_BIT 2
`define RMC_RATE_LSB 0
`define RMC_DET_EN_RST 1'b1
`define RMC_PD_RST 1'b0
`define RMC_HP_SLEEP_DIS_RST 1'b0
`define RMC_RATE_RST 2'h2
// hotplug_and_data_slew_control fields
`define RMC_HP_BLOCK_BIT 6
`define RMC_DSLEW_LSB 0
`define RMC_HP_BLOCK_RST 1'b0
`define RMC_DSLEW_RST 2'h3
// clock_slew_and_link_control fields
`define RMC_CSLEW_LSB 6
`define RMC_CSLEW_RST 2'h1
`define RMC_LINK_RST 5'h10
// byte transport details
`define RMC_BYTE_BITS 8
`define RMC_BIT_CNT_W 4
`endif

// ===== core/rmc_sync_edge.v
// two-flop level synchroniser with edge flags for the serial bus lines
`timescale 1ns/1ns
module rmc_sync_edge
(
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // raw line in
  input wire line_i,
  // synchronised level and edges
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_q; // first stage, only read by stage two
  reg sync_q; // second stage
  reg prev_q; // delayed copy for edge detection

  // idle bus lines sit high, so reset to high
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= line_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule

// ===== core/rmc_ctrl_regs.v
// control register bank of the redriver, reached over the two-wire configuration bus
// Notes on behaviour
// - activity detect enable, resets to one
// - detect off: receiver always normal
// - detect on: standby when no clock activity
// - forced power-down bit, resets to zero
// - hotplug loss powers down while enabled
// - disable bit stops hotplug power-down
// - bus rate field, reset 100 kbps
// - block clear: hotplug passes through
// - block set: source hotplug held low
// - data slew field, reset fastest
// - clock slew field, reset 185 ps
// - reserved bits read zero, writes ignored
// - pointer resets zero, reads auto-increment
`timescale 1ns/1ns
`include "rmc_defines.vh"
module rmc_ctrl_regs
#(
  parameter [6:0] DEV_ADDR = 7'h5E // bus address, arbitrary default
)
(
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // serial configuration bus, open drain data
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // link status from the analog front end
  input wire sink_hotplug_in_i,
  input wire clock_activity_i,
  // hotplug forwarding
  output wire source_hotplug_out_o,
  // power control
  output wire rx_standby_o,
  output wire power_down_o,
  // analog settings
  output wire [1:0] config_bus_rate_select_o,
  output wire [1:0] data_lane_edge_rate_o,
  output wire [1:0] clock_lane_edge_rate_o,
  output wire [4:0] link_ctrl_o
);
  // bus line conditioning
  wire scl_s, scl_rise, scl_fall;
  wire sda_s, sda_rise, sda_fall;
  rmc_sync_edge u_scl (.clk_i(clk_i), .resetn_i(resetn_i), .line_i(scl_i),
    .level_o(scl_s), .rise_o(scl_rise), .fall_o(scl_fall));
  rmc_sync_edge u_sda (.clk_i(clk_i), .resetn_i(resetn_i), .line_i(sda_i),
    .level_o(sda_s), .rise_o(sda_rise), .fall_o(sda_fall));
  wire start_c = sda_fall & scl_s; // data falls while clock high
  wire stop_c = sda_rise & scl_s; // data rises while clock high
  // transfer states
  localparam [2:0] ST_IDLE = 3'h0; // wait for start
  localparam [2:0] ST_ADDR = 3'h1; // shift device address
  localparam [2:0] ST_AACK = 3'h2; // ack the address
  localparam [2:0] ST_WBYTE = 3'h3; // receive pointer or data
  localparam [2:0] ST_WACK = 3'h4; // ack received byte
  localparam [2:0] ST_RBYTE = 3'h5; // send a byte
  localparam [2:0] ST_RACK = 3'h6; // sample host ack
  reg [2:0] state_q, state_d;
  reg [3:0] bit_q, bit_d; // bits shifted in this byte
  reg [7:0] shift_q, shift_d; // in/out shift register
  reg [7:0] ptr_q, ptr_d; // register pointer
  reg have_ptr_q, have_ptr_d; // pointer byte seen in this write
  reg rnw_q, rnw_d; // current transfer is a read
  reg drive_q, drive_d; // pull data low
  reg wr_stb; // commit shift_q at ptr_q
  // control fields
  reg det_en_q, pd_q, hp_sleep_dis_q, hp_block_q;
  reg [1:0] rate_q, dslew_q, cslew_q;
  reg [4:0] link_q; // link bits owned elsewhere, stored here
  reg hp_out_q, standby_q, pdown_q; // registered status outputs
  // register read mux, reserved bits zero
  reg [7:0] rd_data;
  always @*
  begin
    rd_data = 8'h00;
    case (ptr_q)
      `RMC_ADDR_PWR:
      begin
        rd_data[`RMC_DET_EN_BIT] = det_en_q;
        rd_data[`RMC_PD_BIT] = pd_q;
        rd_data[`RMC_HP_SLEEP_DIS_BIT] = hp_sleep_dis_q;
        rd_data[`RMC_RATE_LSB+:2] = rate_q;
      end
      `RMC_ADDR_HPD:
      begin
        rd_data[`RMC_HP_BLOCK_BIT] = hp_block_q;
        rd_data[`RMC_DSLEW_LSB+:2] = dslew_q;
      end
      `RMC_ADDR_CLK:
      begin
        rd_data[`RMC_CSLEW_LSB+:2] = cslew_q;
        rd_data[4:0] = link_q;
      end
      default: rd_data = 8'h00; // unmapped reads zero
    endcase
  end
  // bus protocol engine; state advances on bus clock edges and on start and stop conditions
  always @*
  begin
    state_d = state_q;
    bit_d = bit_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    have_ptr_d = have_ptr_q;
    rnw_d = rnw_q;
    drive_d = drive_q;
    wr_stb = 1'b0;
    if (start_c)
    begin
      // start or repeated start restarts the address phase
      state_d = ST_ADDR;
      bit_d = 4'h0;
      drive_d = 1'b0;
      have_ptr_d = 1'b0;
    end
    else if (stop_c)
    begin
      state_d = ST_IDLE;
      drive_d = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE: drive_d = 1'b0;
        ST_ADDR, ST_WBYTE:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == `RMC_BYTE_BITS)
          begin
            bit_d = 4'h0;
            if (state_q == ST_ADDR)
            begin
              if (shift_q[7:1] == DEV_ADDR)
              begin
                rnw_d = shift_q[0];
                drive_d = 1'b1;
                state_d = ST_AACK;
              end
              else
                state_d = ST_IDLE; // not ours, stay off the bus
            end
            else
            begin
              drive_d = 1'b1;
              state_d = ST_WACK;
              have_ptr_d = 1'b1;
              wr_stb = have_ptr_q; // data bytes applied as the ack goes out
              ptr_d = have_ptr_q ? ptr_q + 8'h01 : shift_q; // first byte sets the pointer
            end
          end
        end
        ST_AACK, ST_WACK: // after a write ack the host owns the data line again
        begin
          if (scl_fall)
          begin
            if (rnw_q && state_q == ST_AACK)
            begin
              // read starts at current pointer
              shift_d = rd_data;
              drive_d = ~rd_data[7];
              bit_d = 4'h1;
              state_d = ST_RBYTE;
            end
            else
            begin
              drive_d = 1'b0;
              state_d = ST_WBYTE;
            end
          end
        end
        ST_RBYTE:
        begin
          if (scl_fall)
          begin
            if (bit_q == `RMC_BYTE_BITS)
            begin
              drive_d = 1'b0; // release for host ack
              state_d = ST_RACK;
            end
            else
            begin
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = ~shift_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            ptr_d = ptr_q + 8'h01; // byte acknowledged or not, advance
            if (sda_s)
              state_d = ST_IDLE; // nack ends the read
          end
          else if (scl_fall)
          begin
            shift_d = rd_data;
            drive_d = ~rd_data[7];
            bit_d = 4'h1;
            state_d = ST_RBYTE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end
  // protocol and status output registers, pointer resets to zero
  // status outputs come from flip-flops, so they trail their inputs by one clock
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= `RMC_PTR_RST;
      have_ptr_q <= 1'b0;
      rnw_q <= 1'b0;
      drive_q <= 1'b0;
      hp_out_q <= 1'b0;
      standby_q <= 1'b0;
      pdown_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      have_ptr_q <= have_ptr_d;
      rnw_q <= rnw_d;
      drive_q <= drive_d;
      hp_out_q <= sink_hotplug_in_i & ~hp_block_q;
      standby_q <= det_en_q & ~clock_activity_i; // off means never standby
      pdown_q <= pd_q | (~hp_sleep_dis_q & ~sink_hotplug_in_i);
    end
  end
  // field storage; writes to reserved bits are dropped
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      det_en_q <= `RMC_DET_EN_RST;
      pd_q <= `RMC_PD_RST;
      hp_sleep_dis_q <= `RMC_HP_SLEEP_DIS_RST;
      rate_q <= `RMC_RATE_RST;
      hp_block_q <= `RMC_HP_BLOCK_RST;
      dslew_q <= `RMC_DSLEW_RST;
      cslew_q <= `RMC_CSLEW_RST;
      link_q <= `RMC_LINK_RST;
    end
    else if (wr_stb)
    begin
      case (ptr_q)
        `RMC_ADDR_PWR:
        begin
          det_en_q <= shift_q[`RMC_DET_EN_BIT];
          pd_q <= shift_q[`RMC_PD_BIT];
          hp_sleep_dis_q <= shift_q[`RMC_HP_SLEEP_DIS_BIT];
          rate_q <= shift_q[`RMC_RATE_LSB+:2]; // all four codes legal
        end
        `RMC_ADDR_HPD:
        begin
          hp_block_q <= shift_q[`RMC_HP_BLOCK_BIT];
          dslew_q <= shift_q[`RMC_DSLEW_LSB+:2];
        end
        `RMC_ADDR_CLK:
        begin
          cslew_q <= shift_q[`RMC_CSLEW_LSB+:2];
          link_q <= shift_q[4:0];
        end
        default: link_q <= link_q; // unmapped writes ignored
      endcase
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_q;
  assign source_hotplug_out_o = hp_out_q;
  assign rx_standby_o = standby_q;
  assign power_down_o = pdown_q;
  assign config_bus_rate_select_o = rate_q;
  assign data_lane_edge_rate_o = dslew_q;
  assign clock_lane_edge_rate_o = cslew_q;
  assign link_ctrl_o = link_q;
endmodule

// ===== verification/rmc_ctrl_regs_properties.sv
// port assertions for the redriver control register bank
`timescale 1ns/1ns
module rmc_ctrl_regs_chk
(
  // clock, reset and inputs
  input wire clk_i,
  input wire resetn_i,
  input wire scl_i,
  input wire sink_hotplug_in_i,
  input wire clock_activity_i,
  // watched outputs
  input wire sda_o,
  input wire sda_oe_o,
  input wire source_hotplug_out_o,
  input wire rx_standby_o,
  input wire [1:0] config_bus_rate_select_o,
  input wire [1:0] data_lane_edge_rate_o,
  input wire [1:0] clock_lane_edge_rate_o,
  input wire [4:0] link_ctrl_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // fields leave reset at their documented codes
  property p_rst;
    !$past(resetn_i) |-> config_bus_rate_select_o == 2'h2 && data_lane_edge_rate_o == 2'h3 &&
      clock_lane_edge_rate_o == 2'h1 && link_ctrl_o == 5'h10;
  endproperty
  a_rst: assert property (p_rst) else $error("fields not at reset codes");
  // a low sink hotplug never reaches the source side
  property p_src;
    !$past(sink_hotplug_in_i) |-> !source_hotplug_out_o;
  endproperty
  a_src: assert property (p_src) else $error("source hotplug without sink hotplug");
  // active clock lane never leaves the receiver in standby
  property p_stb;
    $past(clock_activity_i) |-> !rx_standby_o;
  endproperty
  a_stb: assert property (p_stb) else $error("standby while lane active");
  // field updates land only inside a bus byte, while the bus clock is low
  property p_rate;
    $past(resetn_i) && !$stable(config_bus_rate_select_o) |-> !scl_i;
  endproperty
  a_rate: assert property (p_rate) else $error("rate field moved outside a write");
  property p_dsl;
    $past(resetn_i) && !$stable(data_lane_edge_rate_o) |-> !scl_i;
  endproperty
  a_dsl: assert property (p_dsl) else $error("data slew moved outside a write");
  property p_csl;
    $past(resetn_i) && !$stable(clock_lane_edge_rate_o) |-> !scl_i;
  endproperty
  a_csl: assert property (p_csl) else $error("clock slew moved outside a write");
  property p_lnk;
    $past(resetn_i) && !$stable(link_ctrl_o) |-> !scl_i;
  endproperty
  a_lnk: assert property (p_lnk) else $error("link field moved outside a write");
  // open drain: the data value is always low, and the pull only moves while the bus clock is low
  property p_sda;
    sda_o == 1'b0 && ($stable(sda_oe_o) || !scl_i);
  endproperty
  a_sda: assert property (p_sda) else $error("data line driven high");
endmodule
bind rmc_ctrl_regs rmc_ctrl_regs_chk chk (.*);

// ===== verification/rmc_host_model.sv
// host model of the two-wire configuration bus
`timescale 1ns/1ns
module rmc_host_model
(
  // clock and bus lines
  input wire clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  integer i;
  initial scl_o = 1'b1;
  initial sda_low_o = 1'b0;
  // one phase of 6 clk, above the 3 clk the device needs to sample
  task half;
    begin
      repeat (6) @(posedge clk_i);
      #2;
    end
  endtask
  // start or repeated start; data never moves on a bus clock edge
  task start;
    begin
      sda_low_o = 1'b0;
      half;
      scl_o = 1'b1;
      half;
      sda_low_o = 1'b1;
      half;
      scl_o = 1'b0;
      half;
    end
  endtask
  task stop;
    begin
      sda_low_o = 1'b1;
      half;
      scl_o = 1'b1;
      half;
      sda_low_o = 1'b0;
      half;
    end
  endtask
  // nine clocks msb first: a zero in tx pulls the line low, rx takes its level
  task xfer(input [8:0] tx, output [8:0] rx);
    begin
      for (i = 8; i >= 0; i = i - 1)
      begin
        sda_low_o = ~tx[i];
        half;
        scl_o = 1'b1;
        half;
        rx[i] = sda_i;
        scl_o = 1'b0;
        half;
      end
    end
  endtask
endmodule

// ===== verification/redriver_misc_control_regs_test.sv
// self-checking bench for the redriver control register bank
`timescale 1ns/1ns
module redriver_misc_control_regs_test;
  localparam [6:0] ADR = 7'h5E;
  reg clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg hp = 1'b0;
  reg act = 1'b0;
  reg [7:0] lf = 8'h44;
  reg [7:0] sh [0:15];
  reg [8:0] r;
  reg [7:0] m;
  integer num_errors = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer j;
  wire scl;
  wire sda_low;
  wire sda_o;
  wire oe;
  wire src;
  wire stb;
  wire pd;
  wire [1:0] rate;
  wire [1:0] dsl;
  wire [1:0] csl;
  wire [4:0] lnk;
  // open drain data line with pull-up
  wire sda = ~(sda_low | oe);
  always #20 clk_i = ~clk_i;
  rmc_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  rmc_ctrl_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(oe),
    .sink_hotplug_in_i(hp), .clock_activity_i(act), .source_hotplug_out_o(src), .rx_standby_o(stb),
    .power_down_o(pd), .config_bus_rate_select_o(rate), .data_lane_edge_rate_o(dsl),
    .clock_lane_edge_rate_o(csl), .link_ctrl_o(lnk));
  // lfsr step for repeatable random values
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // bits that a register keeps; reserved places read zero
  function [7:0] msk(input [7:0] a);
    msk = (a == 8'h09) ? 8'hFF : (a == 8'h0A) ? 8'h43 : (a == 8'h0B) ? 8'hDF : 8'h00;
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      host.start;
      host.xfer({ADR, 1'b0, 1'b1}, r);
      chk({7'h0, r[0]}, 8'h00);
      host.xfer({a, 1'b1}, r);
      host.xfer({d, 1'b1}, r);
      host.stop;
      sh[a] = d & msk(a);
    end
  endtask
  // set pointer, repeated start, read n bytes; upper bits of 0x09 lie outside this bank
  task rd(input [7:0] a, input integer n);
    integer i;
    begin
      host.start;
      host.xfer({ADR, 1'b0, 1'b1}, r);
      host.xfer({a, 1'b1}, r);
      host.start;
      host.xfer({ADR, 1'b1, 1'b1}, r);
      for (i = 0; i < n; i = i + 1)
      begin
        host.xfer({8'hFF, i == n - 1}, r);
        m = (a + i == 9) ? 8'h1F : 8'hFF;
        chk(r[8:1] & m, sh[a + i] & m);
      end
      host.stop;
    end
  endtask
  // random status inputs, then outputs against the shadow fields
  task st;
    begin
      @(posedge clk_i);
      #2;
      lf = nx(lf);
      hp = lf[0];
      act = lf[1];
      repeat (2) @(posedge clk_i);
      #2;
      chk({6'h0, src, stb}, {6'h0, hp & ~sh[10][6], sh[9][4] & ~act});
      chk({7'h0, pd}, {7'h0, sh[9][3] | ~(sh[9][2] | hp)});
      chk({2'h0, rate, dsl, csl}, {2'h0, sh[9][1:0], sh[10][1:0], sh[11][7:6]});
      chk({3'h0, lnk}, {3'h0, sh[11][4:0]});
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // hang guard, about twice the expected run
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial
  begin
    for (j = 0; j < 16; j = j + 1)
      sh[j] = 8'h00;
    sh[9] = 8'h12;
    sh[10] = 8'h03;
    sh[11] = 8'h50;
    repeat (8) @(posedge clk_i);
    #2;
    resetn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    st;
    host.start;
    host.xfer({ADR, 1'b1, 1'b1}, r);
    host.xfer({8'hFF, 1'b1}, r);
    host.stop;
    chk(r[8:1], 8'h00);
    rd(8'h09, 3);
    $display("test reset values ended");
    for (j = 0; j < 4; j = j + 1)
    begin
      wr(8'h09, {3'h0, j[0], j[1], j[1] ^ j[0], j[1:0]});
      st;
      wr(8'h0A, 8'hBC | {1'b0, j[0], 4'h0, j[1:0]});
      st;
      wr(8'h0B, {j[1:0], 1'b1, lf[4:0]});
      st;
      rd(8'h09, 3);
    end
    $display("test field codes ended");
    for (j = 0; j < 9; j = j + 1)
    begin
      lf = nx(lf);
      m = lf;
      lf = nx(lf);
      wr(8'h09 + m[1:0] % 3, lf);
      // read with no pointer continues after the last written byte
      host.start;
      host.xfer({ADR, 1'b1, 1'b1}, r);
      host.xfer({8'hFF, 1'b1}, r);
      host.stop;
      chk(r[8:1], sh[8'h0A + m[1:0] % 3]);
      st;
      st;
    end
    $display("test random writes ended");
    host.start;
    host.xfer({ADR ^ 7'h01, 1'b0, 1'b1}, r);
    chk({7'h0, r[0]}, 8'h01);
    host.xfer({8'h0A, 1'b1}, r);
    host.xfer({8'h40, 1'b1}, r);
    host.stop;
    st;
    rd(8'h09, 3);
    $display("test foreign address ended");
    complete_run;
  end
endmodule
